// file: design/lime_pkg.sv
// shared constants and types for the literal and indirect move execution block
// Function
// - load_bank_literal writes its literal (0..31) into the 5-bit bank_select_reg and touches no status flag.
// - load_pc_latch_literal writes its 7-bit literal (0..127) into pc_high_latch and touches no status flag.
// - load_accum_literal writes its 8-bit literal into the accumulator in one cycle and touches no status flag.
// - store_accum_to_file copies the accumulator to the file register at a 7-bit address; nothing else changes.
// - store_accum_indirect decodes pointer_update_mode 00/01/10/11 as pre-inc, pre-dec, post-inc, post-dec by one.
// - the relative form writes to pointer plus a signed offset of -32..31 and leaves the pointer unchanged.
// - indirect_access_alias has no storage; an access to it goes to the address held in the selected pointer_reg.
// - each 16-bit pointer_reg wraps modulo 2^16 when stepped past FFFFh or below 0000h.
// - pointer steps and the indirect store never modify any status flag, wrap included.
// - the configuration load copies the accumulator to the timing configuration register in one cycle, no flags.
package lime_pkg;
    localparam int INSTR_W = 14;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int BANK_W = 5;
    localparam int LATCH_W = 7;
    localparam int FILE_W = 7;
    localparam int OFFS_W = 6;
    // opcode field position and width inside the instruction word
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 10;
    // field positions of the indirect forms
    localparam int IND_SEL_BIT = 2;
    localparam int REL_SEL_BIT = 6;
    // file addresses inside a bank that stand for the two indirect aliases
    localparam logic [FILE_W-1:0] ALIAS0_ADDR = 7'h00;
    localparam logic [FILE_W-1:0] ALIAS1_ADDR = 7'h01;
    // reset values
    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam logic [DATA_W-1:0] TCFG_RST = 8'hFF;
    localparam logic [ADDR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] PTR_ONE = 16'h0001;
    // opcode values
    typedef enum logic [3:0] {
        LIME_OP_NOP = 4'h0,
        LIME_OP_BANK = 4'h1,
        LIME_OP_LATCH = 4'h2,
        LIME_OP_ACCUM = 4'h3,
        LIME_OP_STFILE = 4'h4,
        LIME_OP_STIND = 4'h5,
        LIME_OP_STREL = 4'h6,
        LIME_OP_TCFG = 4'h7
    } lime_op_t;
    // pointer_update_mode encodings
    localparam logic [1:0] MODE_PRE_INC = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
endpackage : lime_pkg

// file: design/lime_pointer_unit.sv
// two 16-bit indirect pointers with step, relative offset and external load
`timescale 1ns/1ps
module lime_pointer_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic step_en,
    input wire logic rel_en,
    input wire logic sel,
    input wire logic [1:0] pointer_update_mode,
    input wire logic signed [lime_pkg::OFFS_W-1:0] offset,
    input wire logic load_en,
    input wire logic load_sel,
    input wire logic [lime_pkg::ADDR_W-1:0] load_value,
    output logic [lime_pkg::ADDR_W-1:0] eff_addr,
    output logic [lime_pkg::ADDR_W-1:0] pointer_reg0,
    output logic [lime_pkg::ADDR_W-1:0] pointer_reg1
);
    import lime_pkg::*;

    // one step up or down; 16-bit result drops the carry so the pointer wraps
    function automatic logic [ADDR_W-1:0] lime_step(input logic [ADDR_W-1:0] p, input logic down);
        lime_step = down ? p - PTR_ONE : p + PTR_ONE;
    endfunction : lime_step

    ////////////////////////////////////////////////////////////////////////
    // selection and address arithmetic
    wire [ADDR_W-1:0] cur = sel ? pointer_reg1 : pointer_reg0;
    wire down = pointer_update_mode[0];
    wire is_pre = ~pointer_update_mode[1];
    wire [ADDR_W-1:0] stepped = lime_step(cur, down);
    wire [ADDR_W-1:0] off_ext = {{(ADDR_W-OFFS_W){offset[OFFS_W-1]}}, offset};
    wire [ADDR_W-1:0] rel_addr = cur + off_ext;
    assign eff_addr = rel_en ? rel_addr : (is_pre ? stepped : cur);
    wire upd0 = step_en & ~rel_en & ~sel;
    wire upd1 = step_en & ~rel_en & sel;

    ////////////////////////////////////////////////////////////////////////
    // pointer registers; a step in the same cycle as an external load wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pointer_reg0 <= PTR_RST;
            pointer_reg1 <= PTR_RST;
        end else begin
            if (upd0) begin
                pointer_reg0 <= stepped;
            end else if (load_en && !load_sel) begin
                pointer_reg0 <= load_value;
            end
            if (upd1) begin
                pointer_reg1 <= stepped;
            end else if (load_en && load_sel) begin
                pointer_reg1 <= load_value;
            end
        end
    end
endmodule : lime_pointer_unit

// file: design/lime_move_exec.sv
// execution of literal loads, accumulator stores and indirect stores
`timescale 1ns/1ps
module lime_move_exec (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [lime_pkg::INSTR_W-1:0] instr_word,
    input wire logic ptr_load_en,
    input wire logic ptr_load_sel,
    input wire logic [lime_pkg::ADDR_W-1:0] ptr_load_value,
    output logic instr_taken,
    output logic mem_we,
    output logic [lime_pkg::ADDR_W-1:0] mem_addr,
    output logic [lime_pkg::DATA_W-1:0] mem_wdata,
    output logic [lime_pkg::DATA_W-1:0] accum,
    output logic [lime_pkg::BANK_W-1:0] bank_select_reg,
    output logic [lime_pkg::LATCH_W-1:0] pc_high_latch,
    output logic [lime_pkg::DATA_W-1:0] timing_cfg,
    output logic [lime_pkg::ADDR_W-1:0] pointer_reg0,
    output logic [lime_pkg::ADDR_W-1:0] pointer_reg1,
    output logic status_we
);
    import lime_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode; opcodes outside this group are left to other units
    wire [3:0] opc = instr_word[OPC_MSB:OPC_LSB];
    wire is_bank = instr_valid && (opc == LIME_OP_BANK);
    wire is_latch = instr_valid && (opc == LIME_OP_LATCH);
    wire is_accum = instr_valid && (opc == LIME_OP_ACCUM);
    wire is_stfile = instr_valid && (opc == LIME_OP_STFILE);
    wire is_stind = instr_valid && (opc == LIME_OP_STIND);
    wire is_strel = instr_valid && (opc == LIME_OP_STREL);
    wire is_tcfg = instr_valid && (opc == LIME_OP_TCFG);
    wire is_nop = instr_valid && (opc == LIME_OP_NOP);
    assign instr_taken = is_bank | is_latch | is_accum | is_stfile | is_stind | is_strel | is_tcfg | is_nop;

    // operand fields
    wire [BANK_W-1:0] lit_bank = instr_word[BANK_W-1:0];
    wire [LATCH_W-1:0] lit_latch = instr_word[LATCH_W-1:0];
    wire [DATA_W-1:0] lit_accum = instr_word[DATA_W-1:0];
    wire [FILE_W-1:0] file_addr = instr_word[FILE_W-1:0];
    wire [1:0] ind_mode = instr_word[1:0];
    wire [OFFS_W-1:0] rel_off = instr_word[OFFS_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // a direct store to an alias address is turned into an indirect store
    wire hit_alias0 = is_stfile && (file_addr == ALIAS0_ADDR);
    wire hit_alias1 = is_stfile && (file_addr == ALIAS1_ADDR);
    wire via_ptr = is_stind | is_strel | hit_alias0 | hit_alias1;
    // alias access reads the pointer as is: relative form with zero offset
    wire use_rel = is_strel | hit_alias0 | hit_alias1;
    wire ptr_sel = is_stind ? instr_word[IND_SEL_BIT] : (is_strel ? instr_word[REL_SEL_BIT] : hit_alias1);
    wire [OFFS_W-1:0] ptr_off = is_strel ? rel_off : {OFFS_W{1'b0}};
    wire [ADDR_W-1:0] ind_addr;
    wire [ADDR_W-1:0] dir_addr = {{(ADDR_W-BANK_W-FILE_W){1'b0}}, bank_select_reg, file_addr};
    wire [ADDR_W-1:0] next_mem_addr = via_ptr ? ind_addr : dir_addr;
    wire next_mem_we = is_stfile | is_stind | is_strel;

    lime_pointer_unit u_ptr (
        .clk_sys(clk_sys),
        .rst(rst),
        .step_en(is_stind),
        .rel_en(use_rel),
        .sel(ptr_sel),
        .pointer_update_mode(ind_mode),
        .offset(ptr_off),
        .load_en(ptr_load_en),
        .load_sel(ptr_load_sel),
        .load_value(ptr_load_value),
        .eff_addr(ind_addr),
        .pointer_reg0(pointer_reg0),
        .pointer_reg1(pointer_reg1)
    );

    ////////////////////////////////////////////////////////////////////////
    // none of these instructions writes a status flag, so the strobe stays low
    assign status_we = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // architectural registers of this group, one cycle per instruction
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            accum <= ACCUM_RST;
            bank_select_reg <= BANK_RST;
            pc_high_latch <= LATCH_RST;
            timing_cfg <= TCFG_RST;
        end else begin
            if (is_accum) begin
                accum <= lit_accum;
            end
            if (is_bank) begin
                bank_select_reg <= lit_bank;
            end
            if (is_latch) begin
                pc_high_latch <= lit_latch;
            end
            if (is_tcfg) begin
                timing_cfg <= accum;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered data-memory write port; the accumulator is never altered here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_we <= 1'h0;
            mem_addr <= PTR_RST;
            mem_wdata <= ACCUM_RST;
        end else begin
            mem_we <= next_mem_we;
            if (next_mem_we) begin
                mem_addr <= next_mem_addr;
                mem_wdata <= accum;
            end
        end
    end
endmodule : lime_move_exec

// file: verif/lime_move_exec_assertions.sv
// concurrent checks on the move execution block ports
`timescale 1ns/1ps
module lime_move_exec_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic ptr_load_en,
    input wire logic instr_taken,
    input wire logic mem_we,
    input wire logic status_we,
    input wire logic [13:0] instr_word,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] pointer_reg0,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] accum,
    input wire logic [7:0] timing_cfg,
    input wire logic [4:0] bank_select_reg,
    input wire logic [6:0] pc_high_latch
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // one accepted instruction of the given opcode
    sequence s_op(logic [3:0] op);
        instr_valid && instr_word[13:10] == op;
    endsequence
    AST_BANK: assert property (s_op(4'h1) |=> bank_select_reg == $past(instr_word[4:0])) else $error("bank");
    AST_LATCH: assert property (s_op(4'h2) |=> pc_high_latch == $past(instr_word[6:0])) else $error("latch");
    AST_ACCUM: assert property (s_op(4'h3) |=> accum == $past(instr_word[7:0])) else $error("accum");
    AST_FILE: assert property (s_op(4'h4) && instr_word[6:1] != 6'h00 |=> mem_we && $stable(accum) &&
        mem_wdata == $past(accum) && mem_addr == {4'h0, $past(bank_select_reg), $past(instr_word[6:0])})
        else $error("file store");
    AST_PREINC: assert property (s_op(4'h5) && instr_word[2:0] == 3'h0 && !ptr_load_en |=>
        pointer_reg0 == $past(pointer_reg0) + 16'h1 && mem_addr == pointer_reg0) else $error("pre step");
    AST_POSTDEC: assert property (s_op(4'h5) && instr_word[2:0] == 3'h3 && !ptr_load_en |=>
        pointer_reg0 == $past(pointer_reg0) - 16'h1 && mem_addr == $past(pointer_reg0)) else $error("post step");
    AST_REL: assert property (s_op(4'h6) && !instr_word[6] && !ptr_load_en |=> $stable(pointer_reg0) &&
        mem_addr == $past(pointer_reg0) + {{10{$past(instr_word[5])}}, $past(instr_word[5:0])}) else $error("rel");
    AST_ALIAS: assert property (s_op(4'h4) && instr_word[6:0] == 7'h00 && !ptr_load_en |=>
        mem_addr == $past(pointer_reg0) && $stable(pointer_reg0)) else $error("alias");
    AST_FLAGS: assert property (s_op(4'h5) or s_op(4'h6) |-> !status_we [*2]) else $error("flags");
    AST_TCFG: assert property (s_op(4'h7) |=> timing_cfg == $past(accum)) else $error("tcfg");
    AST_NOP: assert property (s_op(4'h0) && !ptr_load_en |=> !mem_we && $stable(accum)) else $error("nop");
    AST_REFUSE: assert property (instr_valid && instr_word[13] |-> !instr_taken ##1 !mem_we) else $error("ref");
endmodule : lime_move_exec_assertions
bind lime_move_exec lime_move_exec_assertions u_lime_move_exec_assertions (.clk_sys(clk_sys), .rst(rst),
    .instr_valid(instr_valid), .ptr_load_en(ptr_load_en), .instr_taken(instr_taken), .mem_we(mem_we),
    .status_we(status_we), .instr_word(instr_word), .mem_addr(mem_addr), .pointer_reg0(pointer_reg0),
    .mem_wdata(mem_wdata), .accum(accum), .timing_cfg(timing_cfg), .bank_select_reg(bank_select_reg),
    .pc_high_latch(pc_high_latch));

// file: verif/lime_move_exec_bench.sv
// self-checking bench for the literal and indirect move execution block
`timescale 1ns/1ps
module lime_move_exec_bench;
    import lime_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr_word = '0;
    logic ptr_load_en = 1'b0;
    logic ptr_load_sel = 1'b0;
    logic [ADDR_W-1:0] ptr_load_value = '0;
    logic instr_taken, mem_we, status_we;
    logic [ADDR_W-1:0] mem_addr, pointer_reg0, pointer_reg1;
    logic [DATA_W-1:0] mem_wdata, accum, timing_cfg;
    logic [BANK_W-1:0] bank_select_reg;
    logic [LATCH_W-1:0] pc_high_latch;
    int errors = 0;
    int n_tests = 0;
    lime_move_exec u_lime_move_exec (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .ptr_load_en(ptr_load_en), .ptr_load_sel(ptr_load_sel),
        .ptr_load_value(ptr_load_value), .instr_taken(instr_taken), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .accum(accum), .bank_select_reg(bank_select_reg), .pc_high_latch(pc_high_latch),
        .timing_cfg(timing_cfg), .pointer_reg0(pointer_reg0), .pointer_reg1(pointer_reg1), .status_we(status_we));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // compare one value; zero-extension keeps unknown bits visible
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one instruction for one cycle; sampling waits until that edge has landed
    task automatic issue(input logic [INSTR_W-1:0] w);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    // a pointer write as a neighbouring unit would make it
    task automatic ld_ptr(input logic s, input logic [15:0] v);
        @(posedge clk_sys);
        ptr_load_en <= 1'b1;
        ptr_load_sel <= s;
        ptr_load_value <= v;
        @(posedge clk_sys);
        ptr_load_en <= 1'b0;
    endtask : ld_ptr
    // indirect store: address used, pointer left behind, no flag write
    task automatic ind(input logic [13:0] w, input logic [15:0] ea, input logic [15:0] ep);
        issue(w);
        chk(mem_we, 1'b1);
        chk(mem_addr, ea);
        chk(pointer_reg0, ep);
        chk(status_we, 1'b0);
    endtask : ind
    task automatic t_lit();
        chk(timing_cfg, 8'hFF);
        issue({4'h1, 5'h00, 5'h0F});
        chk(bank_select_reg, 5'h0F);
        issue({4'h2, 3'h0, 7'h7F});
        chk(pc_high_latch, 7'h7F);
        issue({4'h3, 2'h0, 8'hA5});
        chk(accum, 8'hA5);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= {4'h8, 10'h3FF};
        #1 chk(instr_taken, 1'b0);
        issue(14'h0000);
        chk(accum, 8'hA5);
        chk(mem_we, 1'b0);
        $display("literal loads done");
    endtask : t_lit
    task automatic t_file();
        issue({4'h3, 2'h0, 8'h5A});
        issue({4'h4, 3'h0, 7'h7F});
        chk(mem_we, 1'b1);
        chk(mem_addr, 16'h07FF);
        chk(mem_wdata, 8'h5A);
        issue({4'h7, 10'h000});
        chk(timing_cfg, 8'h5A);
        $display("accumulator stores done");
    endtask : t_file
    // wrap both ways, every mode, both offset limits, then the alias
    task automatic t_ind();
        ld_ptr(1'b0, 16'hFFFF);
        ld_ptr(1'b1, 16'h1234);
        ind({4'h5, 7'h0, 3'h0}, 16'h0000, 16'h0000);
        ind({4'h5, 7'h0, 3'h1}, 16'hFFFF, 16'hFFFF);
        ind({4'h5, 7'h0, 3'h2}, 16'hFFFF, 16'h0000);
        ind({4'h5, 7'h0, 3'h3}, 16'h0000, 16'hFFFF);
        ind({4'h5, 7'h0, 3'h4}, 16'h1235, 16'hFFFF);
        chk(pointer_reg1, 16'h1235);
        ind({4'h6, 3'h0, 1'h0, 6'h20}, 16'hFFDF, 16'hFFFF);
        ind({4'h6, 3'h0, 1'h0, 6'h1F}, 16'h001E, 16'hFFFF);
        ind({4'h4, 10'h000}, 16'hFFFF, 16'hFFFF);
        chk(mem_wdata, 8'h5A);
        $display("indirect stores done");
    endtask : t_ind
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_lit();
        t_file();
        t_ind();
        close_out();
    end
endmodule : lime_move_exec_bench
